// [verilog/asm_pkg.sv]
// Shared constants, types and address map of the analog switch bank
package asm_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and answers
  // ----------------------------------------------------------------
  localparam int ASM_AW = 12;
  localparam logic [1:0] ASM_RESP_OKAY = 2'b00;
  localparam logic [1:0] ASM_RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the low ten index bits
  // ----------------------------------------------------------------
  localparam logic [31:0] ASM_IDX_CV = 32'h5000_0044;
  localparam logic [31:0] ASM_IDX_AMP_A = 32'h5000_0045;
  localparam logic [31:0] ASM_IDX_AUX = 32'h5000_0046;
  localparam logic [31:0] ASM_IDX_DSEL = 32'h5000_0047;
  localparam logic [31:0] ASM_IDX_ALIAS = 32'h5000_005C;
  localparam logic [31:0] ASM_IDX_TRIM = 32'h5000_0060;
  localparam logic [31:0] ASM_IDX_PWR = 32'h5000_0061;
  localparam logic [31:0] ASM_IDX_STAT = 32'h5000_0062;

  // ----------------------------------------------------------------
  // Writable masks (reserved bits zero), reset and power-down clear
  // ----------------------------------------------------------------
  localparam logic [3:0][7:0] ASM_MASK = {8'hF3, 8'hFF, 8'hF7, 8'h7F};
  localparam logic [3:0] ASM_PD_CLR = 4'b0111;
  localparam logic [7:0] ASM_BYTE_RST = 8'h00;
  localparam logic [9:0] ASM_TRIM_RST = 10'h000;
  localparam int ASM_TRIM_W = 10;

  // ----------------------------------------------------------------
  // Register field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rsvd;
    logic contact_c_to_amp_g;
    logic contact_f_to_cv;
    logic contact_e_to_cv;
    logic contact_d_to_cv;
    logic contact_c_to_cv;
    logic contact_b_to_cv;
    logic contact_a_to_amp_g;
  } asm_cv_sw_s;

  typedef struct packed {
    logic contact_j_to_amp_a;
    logic contact_g_to_amp_a;
    logic contact_h_to_amp_a;
    logic contact_e_to_amp_a;
    logic rsvd;
    logic contact_h_to_ground;
    logic contact_e_to_ground;
    logic contact_a_to_ground;
  } asm_amp_a_sw_s;

  typedef struct packed {
    logic thermistor1_to_amp_g;
    logic thermistor2_to_ground;
    logic ref_resistor_to_amp_g;
    logic ref_resistor_to_amp_a;
    logic amp_g_gain_pin_mid_en;
    logic amp_g_gain_pin_low_en;
    logic amp_a_gain_pin_mid_en;
    logic amp_a_gain_pin_low_en;
  } asm_aux_sw_s;

  typedef enum logic [3:0] {
    ASM_CH_NONE = 4'b0000,
    ASM_CH_AMP_G = 4'b0001,
    ASM_CH_AMP_A = 4'b0010,
    ASM_CH_F_VS_D = 4'b0100,
    ASM_CH_AUX = 4'b1000
  } asm_chan_e;

  typedef struct packed {
    logic [3:0] adc_channel_code;
    logic [1:0] rsvd;
    logic amp_a_ref_source;
    logic amp_g_ref_source;
  } asm_dsel_s;

  typedef struct packed {
    logic floating;
    logic aux_mux;
    logic f_vs_d;
    logic amp_a;
    logic amp_g;
  } asm_route_s;

  typedef struct packed {
    logic [7:0] q;
  } asm_byte_s;

  typedef struct packed {
    logic awready;
    logic aw_hold;
    logic [ASM_AW-1:0] aw_addr;
    logic wready;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [ASM_TRIM_W-1:0] trim;
    logic pd;
  } asm_bank_s;

  localparam asm_bank_s ASM_BANK_RST = '0;

  function automatic logic [ASM_AW-1:0] asm_byte_addr(logic [31:0] idx);
    asm_byte_addr = {idx[9:0], 2'b00};
  endfunction : asm_byte_addr

endpackage : asm_pkg

// [verilog/asm_byte_reg.sv]
// One byte-wide switch control register with reserved-bit mask
`timescale 1ns/1ps
`default_nettype none
module asm_byte_reg
  import asm_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF,
  parameter logic CLR_PD = 1'b1
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic pd,
  input wire logic we,
  input wire logic [7:0] wdata,
  // Register value
  output logic [7:0] q
);

  asm_byte_s st;
  asm_byte_s next_st;

  always_comb
  begin
    next_st = st;
    if (we)
      next_st.q = wdata & MASK;
    if (CLR_PD && pd)
      next_st.q = ASM_BYTE_RST;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '{q: ASM_BYTE_RST};
    else
      st <= next_st;
  end

  assign q = st.q;

endmodule : asm_byte_reg
`default_nettype wire

// [verilog/asm_adc_route.sv]
// Converter input channel decoder driving the input multiplexer
`timescale 1ns/1ps
`default_nettype none
module asm_adc_route
  import asm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel code
  input wire logic [3:0] adc_channel_code,
  // Multiplexer enables
  output asm_route_s route
);

  asm_route_s st;
  asm_route_s next_st;

  always_comb
  begin
    next_st = '0;
    case (asm_chan_e'(adc_channel_code))
      ASM_CH_AMP_G: next_st.amp_g = 1'b1;
      ASM_CH_AMP_A: next_st.amp_a = 1'b1;
      ASM_CH_AUX: next_st.aux_mux = 1'b1;
      ASM_CH_F_VS_D: next_st.f_vs_d = 1'b1;
      default: next_st.floating = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '{floating: 1'b1, default: 1'b0};
    else
      st <= next_st;
  end

  assign route = st;

endmodule : asm_adc_route
`default_nettype wire

// [verilog/asm_switch_bank.sv]
// Analog switch matrix control bank behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module asm_switch_bank
  import asm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ASM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ASM_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Switch enables toward the analog engine
  output asm_cv_sw_s cv_sw,
  output asm_amp_a_sw_s amp_a_sw,
  output asm_aux_sw_s aux_sw,
  // Converter input and amplifier reference selection
  output asm_dsel_s dsel,
  output asm_route_s adc_route,
  // Reference control
  output logic [ASM_TRIM_W-1:0] cv_trim_code,
  output logic ref_low_power
);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------

  // Index of the byte register at a byte address, 3'd4 when none
  function automatic logic [2:0] byte_reg_sel(logic [ASM_AW-1:0] a);
    if (a == asm_byte_addr(ASM_IDX_CV))
      byte_reg_sel = 3'd0;
    else if (a == asm_byte_addr(ASM_IDX_AMP_A))
      byte_reg_sel = 3'd1;
    else if (a == asm_byte_addr(ASM_IDX_AUX))
      byte_reg_sel = 3'd2;
    else if (a == asm_byte_addr(ASM_IDX_DSEL))
      byte_reg_sel = 3'd3;
    else
      byte_reg_sel = 3'd4;
  endfunction : byte_reg_sel

  function automatic logic addr_known(logic [ASM_AW-1:0] a);
    if (byte_reg_sel(a) != 3'd4)
      addr_known = 1'b1;
    else if (a == asm_byte_addr(ASM_IDX_ALIAS))
      addr_known = 1'b1;
    else if (a == asm_byte_addr(ASM_IDX_TRIM))
      addr_known = 1'b1;
    else if (a == asm_byte_addr(ASM_IDX_PWR))
      addr_known = 1'b1;
    else if (a == asm_byte_addr(ASM_IDX_STAT))
      addr_known = 1'b1;
    else
      addr_known = 1'b0;
  endfunction : addr_known

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  asm_bank_s st;
  asm_bank_s next_st;

  logic [3:0][7:0] reg_q;
  logic [3:0][7:0] reg_wdata;
  logic [3:0] reg_we;
  logic wr_do;
  logic wr_alias;
  logic [2:0] wr_sel;
  logic path_fault;
  logic chan_illegal;
  logic [31:0] rd_data;
  logic rd_known;
  logic [2:0] rd_sel;

  // A write runs once address and data are both held and the
  // previous response has been taken.
  assign wr_do = st.aw_hold && st.w_hold && !st.bvalid;
  assign wr_alias = (st.aw_addr == asm_byte_addr(ASM_IDX_ALIAS));
  assign wr_sel = byte_reg_sel(st.aw_addr);

  // ----------------------------------------------------------------
  // Switch and select registers
  // ----------------------------------------------------------------
  generate
    for (genvar k = 0; k < 4; k++)
    begin : g_reg
      assign reg_we[k] = wr_do &&
        ((wr_sel == 3'(k) && st.wstrb[0]) ||
         (wr_alias && st.wstrb[k]));
      assign reg_wdata[k] = wr_alias ? st.wdata[8*k +: 8] :
        st.wdata[7:0];

      asm_byte_reg #(
        .MASK(ASM_MASK[k]),
        .CLR_PD(ASM_PD_CLR[k])
      ) u_reg (
        .aclk(aclk),
        .aresetn(aresetn),
        .pd(st.pd),
        .we(reg_we[k]),
        .wdata(reg_wdata[k]),
        .q(reg_q[k])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Switch outputs
  // ----------------------------------------------------------------
  // common-voltage switches
  assign cv_sw = asm_cv_sw_s'(reg_q[0]);
  assign amp_a_sw = asm_amp_a_sw_s'(reg_q[1]);
  assign aux_sw = asm_aux_sw_s'(reg_q[2]);
  assign dsel = asm_dsel_s'(reg_q[3]);

  asm_adc_route u_route (
    .aclk(aclk),
    .aresetn(aresetn),
    .adc_channel_code(dsel.adc_channel_code),
    .route(adc_route)
  );

  // ----------------------------------------------------------------
  // Status observed by software
  // ----------------------------------------------------------------
  // thermistor 2 grounded without return path
  assign path_fault = aux_sw.thermistor2_to_ground &&
    !(cv_sw.contact_a_to_amp_g || cv_sw.contact_c_to_amp_g ||
      aux_sw.ref_resistor_to_amp_g || aux_sw.thermistor1_to_amp_g);

  always_comb
  begin
    case (asm_chan_e'(dsel.adc_channel_code))
      ASM_CH_NONE, ASM_CH_AMP_G, ASM_CH_AMP_A,
      ASM_CH_F_VS_D, ASM_CH_AUX: chan_illegal = 1'b0;
      default: chan_illegal = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Read lookup
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_known = addr_known(s_axi_araddr);
    rd_sel = byte_reg_sel(s_axi_araddr);
    rd_data = 32'h0000_0000;
    if (rd_sel != 3'd4)
      rd_data = {24'h00_0000, reg_q[rd_sel[1:0]]};
    else if (s_axi_araddr == asm_byte_addr(ASM_IDX_ALIAS))
      rd_data = reg_q;
    else if (s_axi_araddr == asm_byte_addr(ASM_IDX_TRIM))
      rd_data = {22'h00_0000, st.trim};
    else if (s_axi_araddr == asm_byte_addr(ASM_IDX_PWR))
      rd_data = {31'h0000_0000, st.pd};
    else if (s_axi_araddr == asm_byte_addr(ASM_IDX_STAT))
      rd_data = {29'h0000_0000, chan_illegal, st.pd, path_fault};
  end

  // ----------------------------------------------------------------
  // Bus handshake and own registers
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;

    // Address and data may arrive in either order
    if (s_axi_awvalid && st.awready)
    begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready)
    begin
      next_st.w_hold = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end

    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    if (wr_do)
    begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = addr_known(st.aw_addr) ? ASM_RESP_OKAY :
        ASM_RESP_SLVERR;
      if (st.aw_addr == asm_byte_addr(ASM_IDX_TRIM))
      begin
        if (st.wstrb[0])
          next_st.trim[7:0] = st.wdata[7:0];
        if (st.wstrb[1])
          next_st.trim[9:8] = st.wdata[9:8];
      end
      if (st.aw_addr == asm_byte_addr(ASM_IDX_PWR) && st.wstrb[0])
        next_st.pd = st.wdata[0];
    end

    // Ready drops while a transfer is held or its answer is pending
    next_st.awready = !next_st.aw_hold && !next_st.bvalid;
    next_st.wready = !next_st.w_hold && !next_st.bvalid;

    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_data;
      next_st.rresp = rd_known ? ASM_RESP_OKAY : ASM_RESP_SLVERR;
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= ASM_BANK_RST;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign cv_trim_code = st.trim;
  assign ref_low_power = st.pd;

endmodule : asm_switch_bank
`default_nettype wire

// [tb/asm_switch_bank_sva.sv]
// Assertions on bus timing and switch outputs of the switch bank
`timescale 1ns/1ps
`default_nettype none
module asm_switch_bank_sva
  import asm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [ASM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ASM_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog side
  input wire asm_cv_sw_s cv_sw,
  input wire asm_amp_a_sw_s amp_a_sw,
  input wire asm_aux_sw_s aux_sw,
  input wire asm_dsel_s dsel,
  input wire asm_route_s adc_route,
  input wire logic [ASM_TRIM_W-1:0] cv_trim_code,
  input wire logic ref_low_power
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_RSVD_ZERO: assert property (!cv_sw.rsvd && !amp_a_sw.rsvd
    && dsel.rsvd == 2'b00) else $error("reserved bit set");
  // Reserved codes must still leave the converter floating
  AST_ROUTE: assert property (1'b1 |=> adc_route ==
    ($onehot($past(dsel[7:4])) ? {1'b0, $past(dsel[7:4])} : 5'h10))
    else $error("route wrong");
  AST_PD_CLEAR: assert property (ref_low_power && $past(ref_low_power)
    |-> {cv_sw, amp_a_sw, aux_sw} == 24'h00_0000) else $error("pd kept");
  AST_SW_CAUSE: assert property (!$stable({cv_sw, amp_a_sw, aux_sw, dsel})
    |-> $rose(s_axi_bvalid) || ref_low_power) else $error("switch moved");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no b");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no r");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  cover property (s_axi_bvalid && s_axi_bresp == ASM_RESP_SLVERR);
  cover property ($rose(ref_low_power));
  cover property (adc_route.aux_mux);
endmodule : asm_switch_bank_sva

bind asm_switch_bank asm_switch_bank_sva u_sva (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cv_sw,
  .amp_a_sw, .aux_sw, .dsel, .adc_route, .cv_trim_code, .ref_low_power);
`default_nettype wire

// [tb/analog_switch_matrix_control_test.sv]
// Self-checking bench for the analog switch bank
`timescale 1ns/1ps
`default_nettype none
module analog_switch_matrix_control_test
  import asm_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and register model
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ASM_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ref_low_power, pd;
  logic [ASM_TRIM_W-1:0] cv_trim_code;
  asm_cv_sw_s cv_sw;
  asm_amp_a_sw_s amp_a_sw;
  asm_aux_sw_s aux_sw;
  asm_dsel_s dsel;
  asm_route_s adc_route;
  logic [7:0] m [4];
  int errors = 0;
  int checked = 0;
  int seed = 32'hed24_3723;
  // Writable bits; reserved ones read back zero
  localparam logic [7:0] WMASK [4] = '{8'h7F, 8'hF7, 8'hFF, 8'hF3};
  localparam logic [3:0] CODES [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};

  asm_switch_bank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cv_sw, .amp_a_sw,
    .aux_sw, .dsel, .adc_route, .cv_trim_code, .ref_low_power);

  always #5 aclk = ~aclk;

  function automatic logic [ASM_AW-1:0] ba(logic [31:0] idx);
    return {idx[9:0], 2'b00};
  endfunction : ba

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Response ready raised late at random to stall the slave
  task automatic wr(logic [ASM_AW-1:0] a, logic [31:0] wd, logic [3:0] s,
    logic [1:0] rs);
    int x = $random(seed);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'b11, x[0]};
    for (int n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        chk("bresp", s_axi_bresp, rs);
        s_axi_bready <= 1'b0;
        return;
      end
      s_axi_bready <= 1'b1;
    end
    errors++;
    stop_test();
  endtask : wr

  task automatic rd(logic [ASM_AW-1:0] a, logic [31:0] ed, logic [1:0] rs);
    int x = $random(seed);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= x[0];
    for (int n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", s_axi_rresp, rs);
        s_axi_rready <= 1'b0;
        return;
      end
      s_axi_rready <= 1'b1;
    end
    errors++;
    stop_test();
  endtask : rd

  task automatic put(int k, logic [7:0] v);
    if (!(pd && k < 3))
      m[k] = v & WMASK[k];
  endtask : put

  task automatic wrb(int k, logic [7:0] v, logic [3:0] s);
    wr(ba(ASM_IDX_CV + k), {24'h00_0000, v}, s, ASM_RESP_OKAY);
    if (s[0])
      put(k, v);
  endtask : wrb

  // Route settles one edge after the select register
  task automatic outs();
    logic [3:0] c;
    repeat (2) @(posedge aclk);
    #1;
    c = m[3][7:4];
    chk("cv", cv_sw, m[0]);
    chk("amp_a", amp_a_sw, m[1]);
    chk("aux", aux_sw, m[2]);
    chk("dsel", dsel, m[3]);
    chk("route", adc_route, $onehot(c) ? {1'b0, c} : 5'h10);
    chk("lowpwr", ref_low_power, pd);
  endtask : outs

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, pd} = '0;
    m = '{default: 8'h00};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    outs();
    for (int k = 0; k < 4; k++)
      rd(ba(ASM_IDX_CV + k), 32'h0000_0000, ASM_RESP_OKAY);
    rd(ba(ASM_IDX_TRIM), 32'h0000_0000, ASM_RESP_OKAY);
    $display("reset test done");
    foreach (CODES[i])
    begin
      wrb(3, {CODES[i], 4'hF}, 4'h1);
      outs();
    end
    $display("channel test done");
    // Codes kept to the defined set, grounding path never left open
    for (int i = 0; i < 40; i++)
    begin
      d = $random(seed);
      if (d[10])
      begin
        d[31:28] = CODES[d[26:24] % 5];
        d[22] = 1'b0;
        wr(ba(ASM_IDX_ALIAS), d, d[15:12], ASM_RESP_OKAY);
        for (int k = 0; k < 4; k++)
          if (d[12 + k])
            put(k, d[8*k +: 8]);
        rd(ba(ASM_IDX_ALIAS), {m[3], m[2], m[1], m[0]}, ASM_RESP_OKAY);
      end
      else
      begin
        if (d[9:8] == 2'd3)
          d[7:4] = CODES[d[26:24] % 5];
        if (d[9:8] == 2'd2)
          d[6] = 1'b0;
        wrb(d[9:8], d[7:0], d[15:12]);
        rd(ba(ASM_IDX_CV + d[9:8]), {24'h00_0000, m[d[9:8]]},
          ASM_RESP_OKAY);
      end
      outs();
    end
    $display("random test done");
    wrb(0, 8'h41, 4'h1);
    wrb(2, 8'hEF, 4'h1);
    outs();
    chk("th2", aux_sw.thermistor2_to_ground, 1'b1);
    wr(ba(ASM_IDX_PWR), 32'h0000_0001, 4'h1, ASM_RESP_OKAY);
    pd = 1'b1;
    m = '{8'h00, 8'h00, 8'h00, m[3]};
    wrb(1, 8'hFF, 4'h1);
    outs();
    wr(ba(ASM_IDX_PWR), 32'h0000_0000, 4'h1, ASM_RESP_OKAY);
    pd = 1'b0;
    outs();
    $display("power test done");
    for (int i = 0; i < 2; i++)
    begin
      d = i ? 32'hFFFF_FFFF : $random(seed);
      wr(ba(ASM_IDX_TRIM), d, 4'h3, ASM_RESP_OKAY);
      outs();
      chk("trim", cv_trim_code, d[9:0]);
      rd(ba(ASM_IDX_TRIM), {22'h00_0000, d[9:0]}, ASM_RESP_OKAY);
    end
    wr(12'h1F0, 32'hFFFF_FFFF, 4'hF, ASM_RESP_SLVERR);
    rd(12'h1F0, 32'h0000_0000, ASM_RESP_SLVERR);
    outs();
    $display("error test done");
    stop_test();
  end
endmodule : analog_switch_matrix_control_test
`default_nettype wire
